/* File: pkg/rcr_defs.svh */
// named constants for the respiration control register block
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

// register indices, byte address is four times the index
`define RCR_IDX_W 30
`define RCR_CTRL_IDX 30'h00000002
`define RCR_STAT_IDX 30'h00000003

// control register layout
`define RCR_CTRL_W 24
`define RCR_CTRL_RESET 24'h000000
`define RCR_CTRL_WMASK 24'h01ff06
`define RCR_BIT_EVERY_CYCLE 16
`define RCR_BIT_SYNC_OUT 15
`define RCR_BIT_AMP_BYPASS 14
`define RCR_BIT_OUT_PAIR 13
`define RCR_BIT_CAP_SRC 12
`define RCR_GAIN_HI 11
`define RCR_GAIN_LO 8
`define RCR_FREQ_HI 2
`define RCR_FREQ_LO 1

// status register layout
`define RCR_STAT_GAIN_HI 3
`define RCR_STAT_GAIN_LO 0
`define RCR_STAT_CARRIER 4
`define RCR_STAT_SYNC 5

// gain coding
`define RCR_GAIN_MAX_CODE 4'h9
`define RCR_GAIN_MAX 4'ha
`define RCR_GAIN_STEP 4'h1

// ahb constants
`define RCR_HSIZE_WORD 3'h2
`define RCR_HRESP_OKAY 1'h0

// carrier timing
`define RCR_CLK_HZ 64'd20000000
`define RCR_F_N0 64'd56000
`define RCR_F_N1 64'd54000
`define RCR_F_N2 64'd52000
`define RCR_F_N3 64'd50000
`define RCR_F_P0 64'd64000
`define RCR_F_P1 64'd56900
`define RCR_F_P2 64'd51200
`define RCR_F_P3 64'd48000
`define RCR_ACC_W 24
`define RCR_ACC_SPAN 64'd16777216
`define RCR_CNT_W 12
`define RCR_NCO_INC(f) (24'(((f) * `RCR_ACC_SPAN) / `RCR_CLK_HZ))
`define RCR_HALF_CNT(f) (12'(`RCR_CLK_HZ / (64'd2 * (f))))

`endif

/* File: pkg/rcr_pkg.sv */
// types shared by the respiration control register block
package rcr_pkg;
   typedef enum logic [0:0] {
      RCR_BUS_IDLE = 1'b0,
      RCR_BUS_WRITE = 1'b1
   } rcr_bus_state_t;
   typedef logic [23:0] rcr_ctrl_t;
endpackage

/* File: rtl/rcr_carrier_gen.sv */
// respiration carrier generator, its msb is the sync level
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"
module rcr_carrier_gen
   import rcr_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // configuration
   input wire logic i_every_cycle,
   input wire logic [1:0] i_freq_sel,
   // carrier msb
   output logic o_carrier
);
   logic [`RCR_ACC_W-1:0] acc_reg, acc_next, inc;
   logic [`RCR_CNT_W-1:0] cnt_reg, cnt_next, half;
   logic tog_reg, tog_next;
   logic car_reg, car_next;

   always_comb begin
      case (i_freq_sel)
         2'h0: begin
            inc = `RCR_NCO_INC(`RCR_F_N0);
            half = `RCR_HALF_CNT(`RCR_F_P0);
         end
         2'h1: begin
            inc = `RCR_NCO_INC(`RCR_F_N1);
            half = `RCR_HALF_CNT(`RCR_F_P1);
         end
         2'h2: begin
            inc = `RCR_NCO_INC(`RCR_F_N2);
            half = `RCR_HALF_CNT(`RCR_F_P2);
         end
         default: begin
            inc = `RCR_NCO_INC(`RCR_F_N3);
            half = `RCR_HALF_CNT(`RCR_F_P3);
         end
      endcase
   end

   // periodic mode: integer divider, every cycle identical; otherwise an
   // accumulator hits the mean rate but its cycle length wanders
   always_comb begin
      acc_next = acc_reg;
      cnt_next = cnt_reg;
      tog_next = tog_reg;
      if (i_every_cycle) begin
         if (cnt_reg == '0 || cnt_reg >= half) begin
            cnt_next = half - 12'h001;
            tog_next = ~tog_reg;
         end else begin
            cnt_next = cnt_reg - 12'h001;
         end
      end else begin
         acc_next = acc_reg + inc;
      end
      car_next = i_every_cycle ? tog_next : acc_next[`RCR_ACC_W-1];
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         acc_reg <= '0;
         cnt_reg <= '0;
         tog_reg <= 1'b0;
         car_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         cnt_reg <= cnt_next;
         tog_reg <= tog_next;
         car_reg <= car_next;
      end
   end

   assign o_carrier = car_reg;
endmodule
`default_nettype wire

/* File: rtl/rcr_top.sv */
// respiration control register with ahb-lite slave and carrier sync pin
// Summary of operation
// - the every-cycle bit makes the carrier repeat every cycle, else every N cycles.
// - the sync enable bit drives the carrier dac msb onto general purpose pin three.
// - the pin three sync has a constant period only while the every-cycle bit is one.
// - the bypass bit routes the input past the on-chip amplifier straight to the converter.
// - the drive pair bit selects left leg and right arm at zero, left arm pair at one.
// - the capacitor bit selects internal capacitors at zero and external ones at one.
// - the gain code gives gain code plus one, saturating at ten for codes above 1001.
// - the frequency field with the every-cycle bit sets the carrier, 00 is 56 or 64 khz.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"
module rcr_top
   import rcr_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // analog path controls
   output logic o_carrier_every_cycle_sel,
   output logic o_ext_amp_bypass_en,
   output logic o_cap_source_sel,
   output logic [1:0] o_carrier_freq_sel,
   output logic [3:0] o_resp_input_gain,
   output logic o_drive_out_left_leg,
   output logic o_drive_out_right_arm,
   output logic o_drive_out_left_arm,
   // general purpose pin three
   output logic o_general_io_pin_three,
   output logic o_general_io_pin_three_oe
);
   // bus state
   rcr_bus_state_t bus_reg, bus_next;
   logic [`RCR_IDX_W-1:0] widx_reg, widx_next;
   logic [31:0] rdata_reg, rdata_next;
   logic accept;
   logic [`RCR_IDX_W-1:0] aidx;

   // register state
   rcr_ctrl_t ctrl_reg, ctrl_next;
   logic [3:0] gain_reg, gain_next;
   logic ll_reg, ll_next;
   logic ra_reg, ra_next;
   logic la_reg, la_next;
   logic pin_reg, pin_next;
   logic oe_reg, oe_next;
   logic carrier;
   logic [3:0] code;
   logic [31:0] stat;

   rcr_carrier_gen u_carrier (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_every_cycle(ctrl_reg[`RCR_BIT_EVERY_CYCLE]),
      .i_freq_sel(ctrl_reg[`RCR_FREQ_HI:`RCR_FREQ_LO]),
      .o_carrier(carrier)
   );

   assign accept = i_hsel & i_htrans[1] & i_hready;
   assign aidx = i_haddr[31:2];

   // writes land in the data phase; the read mux looks at ctrl_next so a
   // read right behind a write sees the new word without a wait state
   always_comb begin
      bus_next = RCR_BUS_IDLE;
      widx_next = widx_reg;
      ctrl_next = ctrl_reg;
      case (bus_reg)
         RCR_BUS_WRITE: begin
            if (widx_reg == `RCR_CTRL_IDX) begin
               ctrl_next = rcr_ctrl_t'(i_hwdata[`RCR_CTRL_W-1:0] & `RCR_CTRL_WMASK);
            end
         end
         default: begin
         end
      endcase
      if (accept && i_hwrite && i_hsize == `RCR_HSIZE_WORD) begin
         bus_next = RCR_BUS_WRITE;
         widx_next = aidx;
      end
   end

   // status word shows what the analog path is actually given
   always_comb begin
      stat = '0;
      stat[`RCR_STAT_GAIN_HI:`RCR_STAT_GAIN_LO] = gain_reg;
      stat[`RCR_STAT_CARRIER] = carrier;
      stat[`RCR_STAT_SYNC] = oe_reg;
   end

   // unmapped addresses read as zero
   always_comb begin
      rdata_next = '0;
      if (accept && !i_hwrite) begin
         if (aidx == `RCR_CTRL_IDX) begin
            rdata_next = {8'h00, ctrl_next};
         end else if (aidx == `RCR_STAT_IDX) begin
            rdata_next = stat;
         end
      end
   end

   // derived controls, all registered so each output is a flip-flop
   always_comb begin
      code = ctrl_next[`RCR_GAIN_HI:`RCR_GAIN_LO];
      if (code > `RCR_GAIN_MAX_CODE) begin
         gain_next = `RCR_GAIN_MAX;
      end else begin
         gain_next = code + `RCR_GAIN_STEP;
      end
      la_next = ctrl_next[`RCR_BIT_OUT_PAIR];
      ll_next = ~ctrl_next[`RCR_BIT_OUT_PAIR];
      ra_next = 1'b1;
      // pin is released when sync is off so it stays free for other use
      oe_next = ctrl_reg[`RCR_BIT_SYNC_OUT];
      pin_next = ctrl_reg[`RCR_BIT_SYNC_OUT] & carrier;
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bus_reg <= RCR_BUS_IDLE;
         widx_reg <= '0;
         rdata_reg <= '0;
         ctrl_reg <= `RCR_CTRL_RESET;
         gain_reg <= `RCR_GAIN_STEP;
         ll_reg <= 1'b1;
         ra_reg <= 1'b1;
         la_reg <= 1'b0;
         pin_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         bus_reg <= bus_next;
         widx_reg <= widx_next;
         rdata_reg <= rdata_next;
         ctrl_reg <= ctrl_next;
         gain_reg <= gain_next;
         ll_reg <= ll_next;
         ra_reg <= ra_next;
         la_reg <= la_next;
         pin_reg <= pin_next;
         oe_reg <= oe_next;
      end
   end

   // zero wait states, always okay
   assign o_hreadyout = 1'b1;
   assign o_hresp = `RCR_HRESP_OKAY;
   assign o_hrdata = rdata_reg;
   assign o_carrier_every_cycle_sel = ctrl_reg[`RCR_BIT_EVERY_CYCLE];
   assign o_ext_amp_bypass_en = ctrl_reg[`RCR_BIT_AMP_BYPASS];
   assign o_cap_source_sel = ctrl_reg[`RCR_BIT_CAP_SRC];
   assign o_carrier_freq_sel = ctrl_reg[`RCR_FREQ_HI:`RCR_FREQ_LO];
   assign o_resp_input_gain = gain_reg;
   assign o_drive_out_left_leg = ll_reg;
   assign o_drive_out_right_arm = ra_reg;
   assign o_drive_out_left_arm = la_reg;
   assign o_general_io_pin_three = pin_reg;
   assign o_general_io_pin_three_oe = oe_reg;
endmodule
`default_nettype wire

/* File: testbench/rcr_top_sva.sv */
// assertions for the respiration control register block
`timescale 1ns/100ps
`default_nettype none
module rcr_top_sva (
   input wire logic i_ref_clk, i_sys_rst, i_hsel, i_hwrite, i_hready,
   input wire logic [31:0] i_haddr, i_hwdata, o_hrdata,
   input wire logic [1:0] i_htrans, o_carrier_freq_sel,
   input wire logic [2:0] i_hsize,
   input wire logic [3:0] o_resp_input_gain,
   input wire logic o_carrier_every_cycle_sel, o_ext_amp_bypass_en, o_cap_source_sel,
   input wire logic o_drive_out_left_leg, o_drive_out_right_arm, o_drive_out_left_arm,
   input wire logic o_general_io_pin_three, o_general_io_pin_three_oe
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   logic wr_reg, rd_reg, arm_reg, arm2_reg, pin_reg;
   logic [8:0] cnt_reg;
   wire logic take = i_hsel && i_htrans[1] && i_hready;
   wire logic chg = o_general_io_pin_three != pin_reg;
   // first edge after sync turns on may be a partial half period
   wire logic mode = o_carrier_every_cycle_sel && o_general_io_pin_three_oe && o_carrier_freq_sel == 2'h0;
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         arm_reg <= 1'b0;
         arm2_reg <= 1'b0;
         pin_reg <= 1'b0;
         cnt_reg <= 9'h0;
      end else begin
         wr_reg <= take && i_hwrite && i_hsize == 3'h2 && i_haddr == 32'h8;
         rd_reg <= take && !i_hwrite;
         // the pin may jump as the enable rises, so the next half is partial too
         arm_reg <= mode && (arm_reg || chg);
         arm2_reg <= mode && (arm2_reg || (arm_reg && chg));
         pin_reg <= o_general_io_pin_three;
         cnt_reg <= chg ? 9'h0 : cnt_reg + 9'h1;
      end
   end
   a_write_update: assert property (wr_reg |=>
      o_carrier_every_cycle_sel == $past(i_hwdata[16]) && o_ext_amp_bypass_en == $past(i_hwdata[14])
      && o_cap_source_sel == $past(i_hwdata[12]) && o_drive_out_left_arm == $past(i_hwdata[13]))
      else $error("ctrl outputs do not follow write");
   a_gain_map: assert property (wr_reg |=> o_resp_input_gain ==
      ($past(i_hwdata[11:8]) > 4'h9 ? 4'ha : $past(i_hwdata[11:8]) + 4'h1)) else $error("gain mismatch");
   a_freq_follow: assert property (wr_reg |=> o_carrier_freq_sel == $past(i_hwdata[2:1]))
      else $error("freq select mismatch");
   a_oe_delay: assert property (wr_reg |=> ##1 o_general_io_pin_three_oe == $past(i_hwdata[15], 2))
      else $error("pin enable mismatch");
   a_pin_off: assert property ($fell(o_general_io_pin_three_oe) |-> !o_general_io_pin_three)
      else $error("pin driven while disabled");
   a_drive_pair: assert property (o_drive_out_right_arm && o_drive_out_left_leg != o_drive_out_left_arm)
      else $error("drive pair invalid");
   a_sync_period: assert property (mode && arm2_reg && chg |-> cnt_reg == 9'd155)
      else $error("sync half period wrong");
   a_read_reserved: assert property (rd_reg |-> o_hrdata[31:17] == 15'h0)
      else $error("reserved bits nonzero");
   c_write: cover property (wr_reg);
   c_read: cover property (rd_reg);
   c_sat: cover property (wr_reg && i_hwdata[11:8] > 4'h9);
   c_period: cover property (mode && arm2_reg && chg);
endmodule
bind rcr_top rcr_top_sva u_rcr_top_sva (.*);
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the respiration control register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module testbench;
   import rcr_pkg::*;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, q;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, c;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [11:0] e;
   wire logic [31:0] hrdata;
   wire logic rdy, resp, every, byp, cap, ll, ra, la, pin, oe;
   wire logic [1:0] freq;
   wire logic [3:0] gain;
   int bad_count = 0, checks_done = 0, n, t;
   // written word, expected read back, expected gain multiplier
   logic [31:0] rows [5][3] = '{'{32'h0, 32'h0, 32'h1}, '{32'h900, 32'h900, 32'ha}, '{32'h800, 32'h800, 32'h9},
      '{32'hfffeffff, 32'hff06, 32'ha}, '{32'h17202, 32'h17202, 32'h3}};
   rcr_top u_rcr_top (.i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
      .o_hreadyout(rdy), .o_hresp(resp), .o_carrier_every_cycle_sel(every), .o_ext_amp_bypass_en(byp),
      .o_cap_source_sel(cap), .o_carrier_freq_sel(freq), .o_resp_input_gain(gain), .o_drive_out_left_leg(ll),
      .o_drive_out_right_arm(ra), .o_drive_out_left_arm(la), .o_general_io_pin_three(pin),
      .o_general_io_pin_three_oe(oe));
   always #25 clk = ~clk;
   task automatic xfer(input logic [31:0] a, d, input logic w, input logic [2:0] s);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= s;
      do @(posedge clk); while (rdy !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = hrdata;
   endtask
   // cycles until the pin next changes
   task automatic half();
      q = pin; n = 0;
      while (pin === q && n < 3000) begin @(posedge clk); n++; end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge clk);
      `CHK({hrdata, rdy, resp, ll, ra, la, gain, pin, oe}, {32'h0, 5'b10110, 4'h1, 2'b00})
      rst <= 1'b0;
      foreach (rows[i]) begin
         c = rows[i][1];
         xfer(32'h8, rows[i][0], 1'b1, 3'h2);
         xfer(32'h8, 32'h0, 1'b0, 3'h2);
         `CHK(rd, c)
         e = {c[16], c[14], c[12], c[2:1], !c[13], c[13], 1'b1, rows[i][2][3:0]};
         `CHK({every, byp, cap, freq, ll, la, ra, gain}, e)
      end
      $display("table rows done");
      xfer(32'h8, 32'h400, 1'b1, 3'h1);
      xfer(32'h14, 32'h400, 1'b1, 3'h2);
      xfer(32'hc, 32'h1ff06, 1'b1, 3'h2);
      xfer(32'h8, 32'h0, 1'b0, 3'h2);
      `CHK(rd, 32'h17202)
      xfer(32'h10, 32'h0, 1'b0, 3'h2);
      `CHK(rd, 32'h0)
      xfer(32'hc, 32'h0, 1'b0, 3'h2);
      `CHK({rd[31:5], rd[3:0]}, {27'h0, 4'h3})
      $display("refusal tests done");
      xfer(32'h8, 32'h18000, 1'b1, 3'h2);
      half(); half(); half();
      `CHK(n, 156)
      `CHK(oe, 1'b1)
      xfer(32'h8, 32'h8000, 1'b1, 3'h2);
      t = 0;
      repeat (20000) begin q = pin; @(posedge clk); if (pin !== q) t++; end
      // mean rate only, the accumulator makes single periods jitter
      `CHK(t inside {[110:114]}, 1'b1)
      xfer(32'h8, 32'h0, 1'b1, 3'h2);
      repeat (2) @(posedge clk);
      `CHK({oe, pin}, 2'b00)
      $display("carrier tests done");
      end_of_test();
   end
endmodule
`default_nettype wire
